// file: logic/analog_input_scaling_curves.v
// four analog input scaling curves: select, filter, range check, interpolate, round
`timescale 1ns/10ps
`include "scaling_defines.vh"
module analog_input_scaling_curves #(
   parameter TICK_CYCLES = `UPDATE_STEP_US * `CLK_FREQ_MHZ
) (
   // clock and reset
   input wire clk_in,
   input wire arst_n_in,
   // enables
   input wire scaling_enable_in,
   input wire [`NCURVE-1:0] curve_enable_in,
   // per-curve configuration
   input wire [`NCURVE*`SELW-1:0] source_select_in,
   input wire [`NCURVE-1:0] filter_enable_in,
   input wire [`NCURVE*`TW-1:0] filter_tau_in,
   input wire [`NCURVE-1:0] range_check_in,
   input wire [`NCURVE*`VW-1:0] limit_min_in,
   input wire [`NCURVE*`VW-1:0] limit_max_in,
   input wire [`NCURVE*`TW-1:0] update_cycle_in,
   input wire [`NCURVE*2-1:0] handling_in,
   input wire [`NCURVE*`NPT-1:0] point_used_in,
   input wire [`NCURVE*`NPT*`VW-1:0] point_x_in,
   input wire [`NCURVE*`NPT*`VW-1:0] point_y_in,
   // measurements
   input wire [`NSRC*`VW-1:0] source_value_in,
   input wire [`NSRC-1:0] source_valid_in,
   // results
   output wire [`NCURVE*`VW-1:0] curve_input_out,
   output wire [`NCURVE*`VW-1:0] curve_output_out,
   output wire [`NCURVE-1:0] curve_input_out_of_range_out,
   output wire [`NCURVE-1:0] curve_updated_out
);
   localparam S_IDLE = 2'h0;
   localparam S_FILT = 2'h1;
   localparam S_SEG = 2'h2;
   localparam S_INTERP = 2'h3;
   localparam [`TW-1:0] TICK_LAST = TICK_CYCLES - 1;
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function [`VW-1:0] mag;
      input signed [`VW-1:0] v;
      mag = v[`VW-1] ? -v : v;
   endfunction

   function signed [`VW-1:0] round_val;
      input signed [`VW-1:0] v;
      input [1:0] mode;
      reg signed [`VW-1:0] q;
      reg signed [`VW-1:0] r;
      reg signed [`VW-1:0] qn;
      reg signed [`VW-1:0] vn;
      begin
         q = v / `VAL_ONE;
         r = v - q * `VAL_ONE;
         vn = v + `VAL_HALF;
         qn = vn / `VAL_ONE;
         if ((vn - qn * `VAL_ONE) < `VAL_ZERO)
            qn = qn - 48'sh000000000001;
         case (mode)
            `HANDLE_FLOOR: round_val = ((r < `VAL_ZERO) ? q - 48'sh000000000001 : q) * `VAL_ONE;
            `HANDLE_CEIL: round_val = ((r > `VAL_ZERO) ? q + 48'sh000000000001 : q) * `VAL_ONE;
            `HANDLE_NEAR: round_val = qn * `VAL_ONE;
            default: round_val = v;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   reg [1:0] state_reg;
   reg [1:0] cur_reg;
   reg [`TW-1:0] tick_cnt_reg;
   reg [`TW-1:0] cyc_cnt_reg [0:`NCURVE-1];
   reg [`NCURVE-1:0] pending_reg;
   reg [`NCURVE-1:0] updated_reg;
   reg [`NCURVE-1:0] range_reg;
   reg signed [`VW-1:0] raw_reg [0:`NCURVE-1];
   reg signed [`VW-1:0] filt_reg [0:`NCURVE-1];
   reg signed [`VW-1:0] input_reg [0:`NCURVE-1];
   reg signed [`VW-1:0] output_reg [0:`NCURVE-1];
   reg signed [`VW-1:0] work_reg;
   reg signed [`VW-1:0] base_reg;
   reg [`NW-1:0] div_num_reg;
   reg [`VW:0] div_rem_reg;
   reg [`VW-1:0] div_den_reg;
   reg div_neg_reg;
   reg div_zero_reg;
   reg [6:0] div_cnt_reg;
   wire tick = (tick_cnt_reg == TICK_LAST);
   wire [`NCURVE-1:0] active = {`NCURVE{scaling_enable_in}} & curve_enable_in;
   // ----------------------------------------------------------------------
   // combinational selection of source, segment and divider step
   // ----------------------------------------------------------------------
   reg [1:0] pick;
   reg [`SELW-1:0] sel;
   reg signed [`VW-1:0] sample;
   reg signed [`VW-1:0] fdiff;
   reg [`TW-1:0] dt;
   reg [`TW:0] fden;
   integer i;
   integer lo;
   integer hi;
   integer last;
   reg signed [`VW-1:0] x_lo;
   reg signed [`VW-1:0] x_hi;
   reg signed [`VW-1:0] y_lo;
   reg signed [`VW-1:0] y_hi;
   reg [`VW:0] trial;
   reg signed [`VW-1:0] div_q;
   reg signed [`VW-1:0] result;

   always @* begin
      pick = 2'h0;
      for (i = `NCURVE - 1; i >= 0; i = i - 1)
         if (pending_reg[i])
            pick = i[1:0];
      sel = source_select_in[pick*`SELW +: `SELW];
      // a lost or unmapped source keeps the last good sample
      if (sel < `SRC_CODE_LIMIT && source_valid_in[sel])
         sample = source_value_in[sel*`VW +: `VW];
      else
         sample = raw_reg[pick];
      fdiff = sample - filt_reg[pick];
      dt = update_cycle_in[pick*`TW +: `TW];
      if (dt == {`TW{1'b0}})
         dt = {{(`TW-1){1'b0}}, 1'b1};
      fden = {1'b0, filter_tau_in[pick*`TW +: `TW]} + {1'b0, dt};
      last = 1;
      for (i = 0; i < `NPT; i = i + 1)
         if (i < 2 || point_used_in[cur_reg*`NPT + i])
            last = i;
      lo = 0;
      for (i = 0; i < `NPT; i = i + 1)
         if ((i < 2 || point_used_in[cur_reg*`NPT + i]) && i != last &&
             $signed(point_x_in[(cur_reg*`NPT + i)*`VW +: `VW]) <= work_reg)
            lo = i;
      hi = last;
      for (i = `NPT - 1; i >= 0; i = i - 1)
         if ((i < 2 || point_used_in[cur_reg*`NPT + i]) && i > lo)
            hi = i;
      x_lo = point_x_in[(cur_reg*`NPT + lo)*`VW +: `VW];
      x_hi = point_x_in[(cur_reg*`NPT + hi)*`VW +: `VW];
      y_lo = point_y_in[(cur_reg*`NPT + lo)*`VW +: `VW];
      y_hi = point_y_in[(cur_reg*`NPT + hi)*`VW +: `VW];
      trial = {div_rem_reg[`VW-1:0], div_num_reg[`NW-1]};
      div_q = div_neg_reg ? -$signed(div_num_reg[`VW-1:0]) : $signed(div_num_reg[`VW-1:0]);
      result = div_zero_reg ? base_reg : base_reg + div_q;
   end
   // ----------------------------------------------------------------------
   // update cycle timing
   // ----------------------------------------------------------------------
   integer c, f, p;
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_cnt_reg <= {`TW{1'b0}};
         for (c = 0; c < `NCURVE; c = c + 1)
            cyc_cnt_reg[c] <= {`TW{1'b0}};
      end else begin
         tick_cnt_reg <= tick ? {`TW{1'b0}} : tick_cnt_reg + 16'h0001;
         for (c = 0; c < `NCURVE; c = c + 1) begin
            if (!active[c])
               cyc_cnt_reg[c] <= {`TW{1'b0}};
            else if (tick)
               cyc_cnt_reg[c] <= (cyc_cnt_reg[c] + 16'h0001 >= update_cycle_in[c*`TW +: `TW]) ?
                                 {`TW{1'b0}} : cyc_cnt_reg[c] + 16'h0001;
         end
      end
   end

   reg [`NCURVE-1:0] fire;
   reg [`NCURVE-1:0] served;
   always @* begin
      for (f = 0; f < `NCURVE; f = f + 1)
         fire[f] = active[f] && tick &&
                   (cyc_cnt_reg[f] + 16'h0001 >= update_cycle_in[f*`TW +: `TW]);
      served = {`NCURVE{1'b0}};
      if (state_reg == S_IDLE && pending_reg != {`NCURVE{1'b0}})
         served[pick] = 1'b1;
   end

   // ----------------------------------------------------------------------
   // processing sequence
   // ----------------------------------------------------------------------
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= S_IDLE;
         cur_reg <= 2'h0;
         pending_reg <= {`NCURVE{1'b0}};
         updated_reg <= {`NCURVE{1'b0}};
         range_reg <= {`NCURVE{1'b0}};
         work_reg <= `VAL_ZERO;
         base_reg <= `VAL_ZERO;
         div_num_reg <= {`NW{1'b0}};
         div_rem_reg <= {(`VW+1){1'b0}};
         div_den_reg <= {`VW{1'b0}};
         div_neg_reg <= 1'b0;
         div_zero_reg <= 1'b0;
         div_cnt_reg <= 7'h00;
         for (p = 0; p < `NCURVE; p = p + 1) begin
            raw_reg[p] <= `VAL_ZERO;
            filt_reg[p] <= `VAL_ZERO;
            input_reg[p] <= `VAL_ZERO;
            output_reg[p] <= `VAL_ZERO;
         end
      end else begin
         // a new request beats the service clear
         pending_reg <= ((pending_reg & ~served) | fire) & active;
         updated_reg <= {`NCURVE{1'b0}};
         if (div_cnt_reg != 7'h00) begin
            div_cnt_reg <= div_cnt_reg - 7'h01;
            if (trial >= {1'b0, div_den_reg}) begin
               div_rem_reg <= trial - {1'b0, div_den_reg};
               div_num_reg <= {div_num_reg[`NW-2:0], 1'b1};
            end else begin
               div_rem_reg <= trial;
               div_num_reg <= {div_num_reg[`NW-2:0], 1'b0};
            end
         end
         case (state_reg)
            S_IDLE: begin
               if (served != {`NCURVE{1'b0}}) begin
                  cur_reg <= pick;
                  raw_reg[pick] <= sample;
                  div_rem_reg <= {(`VW+1){1'b0}};
                  div_zero_reg <= 1'b0;
                  if (filter_enable_in[pick]) begin
                     // alpha = dt/(tau+dt): steady input converges to itself
                     base_reg <= filt_reg[pick];
                     div_num_reg <= mag(fdiff) * {{(`VW-`TW){1'b0}}, dt};
                     div_den_reg <= {{(`VW-`TW-1){1'b0}}, fden};
                     div_neg_reg <= fdiff[`VW-1];
                     div_cnt_reg <= `DIV_STEPS;
                     state_reg <= S_FILT;
                  end else begin
                     work_reg <= sample;
                     filt_reg[pick] <= sample;
                     state_reg <= S_SEG;
                  end
               end
            end
            S_FILT: begin
               if (div_cnt_reg == 7'h00) begin
                  work_reg <= result;
                  filt_reg[cur_reg] <= result;
                  state_reg <= S_SEG;
               end
            end
            S_SEG: begin
               // slope product needs the full width before the divide
               base_reg <= y_lo;
               div_num_reg <= mag(work_reg - x_lo) * mag(y_hi - y_lo);
               div_den_reg <= mag(x_hi - x_lo);
               div_neg_reg <= (work_reg < x_lo) ^ (y_hi < y_lo) ^ (x_hi < x_lo);
               div_zero_reg <= (x_hi == x_lo);
               div_rem_reg <= {(`VW+1){1'b0}};
               div_cnt_reg <= `DIV_STEPS;
               if (active[cur_reg])
                  input_reg[cur_reg] <= work_reg;
               range_reg[cur_reg] <= range_check_in[cur_reg] &&
                  (work_reg < $signed(limit_min_in[cur_reg*`VW +: `VW]) ||
                   work_reg > $signed(limit_max_in[cur_reg*`VW +: `VW]));
               state_reg <= S_INTERP;
            end
            S_INTERP: begin
               if (div_cnt_reg == 7'h00) begin
                  output_reg[cur_reg] <= round_val(result, handling_in[cur_reg*2 +: 2]);
                  updated_reg[cur_reg] <= active[cur_reg];
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
         // a curve switched off mid-way is dropped, so stale settings never finish
         if (state_reg != S_IDLE && !active[cur_reg])
            state_reg <= S_IDLE;
         for (p = 0; p < `NCURVE; p = p + 1)
            if (!active[p]) begin
               range_reg[p] <= 1'b0;
               output_reg[p] <= `VAL_ZERO;
            end
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `NCURVE; g = g + 1) begin : flat
         assign curve_input_out[g*`VW +: `VW] = input_reg[g];
         assign curve_output_out[g*`VW +: `VW] = output_reg[g];
      end
   endgenerate
   assign curve_input_out_of_range_out = range_reg;
   assign curve_updated_out = updated_reg;
endmodule

// file: logic/scaling_defines.vh
// constants for the four-curve analog input scaling block
`ifndef SCALING_DEFINES_VH
`define SCALING_DEFINES_VH
// ----------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------
`define VW 48
`define NW 96
`define TW 16
`define NCURVE 4
`define NPT 20
`define NSRC 42
`define SELW 6
`define DIV_STEPS 7'h60
// ----------------------------------------------------------------------
// fixed point: one unit is 100000 counts of 0.00001
// ----------------------------------------------------------------------
`define VAL_ONE 48'sh0000000186a0
`define VAL_HALF 48'sh00000000c350
`define VAL_ZERO 48'sh000000000000
// ----------------------------------------------------------------------
// codes and configuration defaults
// ----------------------------------------------------------------------
`define HANDLE_FLOAT 2'h0
`define HANDLE_FLOOR 2'h1
`define HANDLE_CEIL 2'h2
`define HANDLE_NEAR 2'h3
`define SRC_SEL_DEFAULT 6'h00
`define SRC_CODE_LIMIT 6'h2a
`define FILTER_TAU_DEFAULT 16'h00c8
`define UPDATE_CYCLE_DEFAULT 16'h001e
`define POINT2_X_DEFAULT 48'h0000000186a0
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define UPDATE_STEP_US 5000
`define CLK_FREQ_MHZ 10
`endif

// file: tb/scaling_front_end_model.sv
// behavioural measurement front end feeding the scaling curves
`timescale 1ns/10ps
`include "scaling_defines.vh"
module scaling_front_end_model (
   // clock
   input wire clk_in,
   // measurements
   output reg [`NSRC*`VW-1:0] source_value_out,
   output reg [`NSRC-1:0] source_valid_out
);
   reg [`VW-1:0] level_reg [0:`NSRC-1];
   integer s;
   integer t;
   initial begin
      source_value_out = 0;
      source_valid_out = {`NSRC{1'b1}};
      for (s = 0; s < `NSRC; s = s + 1) level_reg[s] = 0;
   end
   // a lost line flips to its complement every cycle, so its last value shows only on alternate cycles
   always @(negedge clk_in) begin
      for (t = 0; t < `NSRC; t = t + 1)
         source_value_out[t*`VW+:`VW] <= source_valid_out[t] ? level_reg[t] :
            ~source_value_out[t*`VW+:`VW];
   end
   task set_level(input integer idx, input [`VW-1:0] v);
      begin
         level_reg[idx] = v;
         source_valid_out[idx] = 1'h1;
      end
   endtask
   task drop(input integer idx);
      source_valid_out[idx] = 1'h0;
   endtask
endmodule

// file: tb/analog_input_scaling_curves_asserts.sv
// port-level assertions for the analog input scaling curves
`timescale 1ns/10ps
`include "scaling_defines.vh"
module scaling_curves_checker (
   // clock, reset and settings
   input wire clk_in,
   input wire arst_n_in,
   input wire scaling_enable_in,
   input wire [`NCURVE-1:0] curve_enable_in,
   input wire [`NCURVE-1:0] range_check_in,
   input wire [`NCURVE*`VW-1:0] limit_min_in,
   input wire [`NCURVE*`VW-1:0] limit_max_in,
   input wire [`NCURVE*2-1:0] handling_in,
   // results
   input wire [`NCURVE*`VW-1:0] curve_input_out,
   input wire [`NCURVE*`VW-1:0] curve_output_out,
   input wire [`NCURVE-1:0] curve_input_out_of_range_out,
   input wire [`NCURVE-1:0] curve_updated_out
);
   wire signed [`VW-1:0] in0 = curve_input_out[`VW-1:0];
   wire signed [`VW-1:0] out0 = curve_output_out[`VW-1:0];
   wire signed [`VW-1:0] in3 = curve_input_out[4*`VW-1:3*`VW];
   wire signed [`VW-1:0] mn0 = limit_min_in[`VW-1:0];
   wire signed [`VW-1:0] mx0 = limit_max_in[`VW-1:0];
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   property p_global_off;
      !scaling_enable_in [*2] |-> curve_output_out == 0 && curve_updated_out == 0
         && curve_input_out_of_range_out == 0;
   endproperty
   a_global_off: assert property (p_global_off) else $error("output alive while off");
   property p_curve_off;
      !curve_enable_in[3] [*2] |-> curve_output_out[4*`VW-1:3*`VW] == 0
         && !curve_updated_out[3] && !curve_input_out_of_range_out[3];
   endproperty
   a_curve_off: assert property (p_curve_off) else $error("disabled curve active");
   property p_monitor_hold;
      (scaling_enable_in && !curve_enable_in[3]) [*3] |=> $stable(in3);
   endproperty
   a_monitor_hold: assert property (p_monitor_hold) else $error("monitor moved");
   property p_range_flag;
      curve_updated_out[0] |-> curve_input_out_of_range_out[0] ==
         (range_check_in[0] && (in0 < mn0 || in0 > mx0));
   endproperty
   a_range_flag: assert property (p_range_flag) else $error("range flag wrong");
   property p_pulse_single;
      curve_updated_out[0] |=> !curve_updated_out[0] [*8];
   endproperty
   a_pulse_single: assert property (p_pulse_single) else $error("update pulse too long");
   property p_out_on_update;
      scaling_enable_in && curve_enable_in[0] && $changed(out0) |-> curve_updated_out[0];
   endproperty
   a_out_on_update: assert property (p_out_on_update) else $error("output moved");
   property p_input_then_output;
      scaling_enable_in && $changed(in0) |->
         ##[1:300] (curve_updated_out[0] || !scaling_enable_in || !curve_enable_in[0]);
   endproperty
   a_input_then_output: assert property (p_input_then_output) else $error("no output");
   property p_rounded;
      curve_updated_out[0] && handling_in[1:0] != `HANDLE_FLOAT |-> out0 % `VAL_ONE == `VAL_ZERO;
   endproperty
   a_rounded: assert property (p_rounded) else $error("result not integer");
endmodule
bind analog_input_scaling_curves scaling_curves_checker u_chk (.clk_in, .arst_n_in,
   .scaling_enable_in, .curve_enable_in, .range_check_in, .limit_min_in, .limit_max_in,
   .handling_in, .curve_input_out, .curve_output_out, .curve_input_out_of_range_out,
   .curve_updated_out);

// file: tb/analog_input_scaling_curves_tb_top.sv
// self-checking bench for the four analog input scaling curves
`timescale 1ns/10ps
`include "scaling_defines.vh"
module analog_input_scaling_curves_tb_top;
   // tick must outlast four curves served back to back, or low indices starve the rest
   localparam TICK = 500;
   localparam [47:0] CORNERS = {6'h29, 6'h27, 6'h17, 6'h03, 6'h28, 6'h18, 6'h04, 6'h00};
   reg clk = 1'h0;
   reg arst_n = 1'h0;
   reg en = 1'h0;
   reg [3:0] cen = 4'h0, fen = 4'h0, rchk = 4'h0, seen;
   reg [23:0] sel = 24'h0;
   reg [63:0] tau = 64'h0, upd = 64'h0;
   reg [191:0] mn = 192'h0, mx = 192'h0;
   reg [7:0] hnd = 8'h0;
   reg [79:0] used = 80'h0;
   reg [3839:0] px = 3840'h0, py = 3840'h0;
   wire [2015:0] sv;
   wire [41:0] sok;
   wire [191:0] cin, cout;
   wire [3:0] oor, updp;
   integer n_fail = 0, n_checks = 0, seed = 91, k, j, c;
   time tp, t1;
   reg signed [47:0] src_lvl [0:41];
   reg signed [47:0] a, b, v;
   initial forever #50 clk = ~clk;
   scaling_front_end_model u_fe (.clk_in(clk), .source_value_out(sv), .source_valid_out(sok));
   analog_input_scaling_curves #(.TICK_CYCLES(TICK)) u_dut (.clk_in(clk), .arst_n_in(arst_n),
      .scaling_enable_in(en), .curve_enable_in(cen), .source_select_in(sel),
      .filter_enable_in(fen), .filter_tau_in(tau), .range_check_in(rchk), .limit_min_in(mn),
      .limit_max_in(mx), .update_cycle_in(upd), .handling_in(hnd), .point_used_in(used),
      .point_x_in(px), .point_y_in(py), .source_value_in(sv), .source_valid_in(sok),
      .curve_input_out(cin), .curve_output_out(cout), .curve_input_out_of_range_out(oor),
      .curve_updated_out(updp));
   function signed [47:0] pxs(input integer cv, input integer i);
      pxs = px[(cv*20+i)*48+:48];
   endfunction
   function signed [47:0] pys(input integer cv, input integer i);
      pys = py[(cv*20+i)*48+:48];
   endfunction
   // interpolate, then round; quotient truncates toward zero
   function signed [47:0] expect_out(input signed [47:0] x, x1, y1, x2, y2, input [1:0] m);
      reg signed [95:0] q;
      reg signed [47:0] r;
      begin
         q = y1 + (x - x1) * (y2 - y1) / (x2 - x1);
         if (m == `HANDLE_NEAR) q = q + `VAL_HALF;
         r = q % `VAL_ONE;
         if (m != `HANDLE_FLOAT) q = q - r;
         if (m != `HANDLE_FLOAT && m != `HANDLE_CEIL && r < 0) q = q - `VAL_ONE;
         if (m == `HANDLE_CEIL && r > 0) q = q + `VAL_ONE;
         expect_out = q;
      end
   endfunction
   task compare(input [47:0] got, input [47:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task check_curve(input integer cv);
      reg signed [47:0] x, e;
      integer s;
      begin
         x = src_lvl[sel[cv*6+:6]];
         s = (used[cv*20+2] && x >= pxs(cv, 1)) ? 1 : 0;
         e = expect_out(x, pxs(cv, s), pys(cv, s), pxs(cv, s + 1), pys(cv, s + 1), hnd[cv*2+:2]);
         compare(cin[cv*48+:48], x);
         compare(cout[cv*48+:48], e);
         compare(oor[cv], rchk[cv] && (x < $signed(mn[cv*48+:48]) || x > $signed(mx[cv*48+:48])));
      end
   endtask
   // waits until every enabled curve has refreshed once
   task wait_all;
      integer n;
      begin
         seen = 4'h0;
         for (n = 0; n < 12 * TICK && seen != cen; n = n + 1) begin
            @(posedge clk);
            #1;
            for (j = 0; j < 4; j = j + 1) if (updp[j] && !seen[j]) begin
               if (!fen[j]) check_curve(j);
               if (j == 0) tp = $time;
               seen[j] = 1'h1;
            end
         end
         compare(seen, cen);
      end
   endtask
   task summarize;
      begin
         $display("checks=%0d errors=%0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      // scenarios need roughly 50k cycles
      #8000000;
      n_fail = n_fail + 1;
      summarize;
   end
   // ---------------------------------------------
   // random curves with corner sources and codes
   // ---------------------------------------------
   initial begin
      for (k = 0; k < 42; k = k + 1) src_lvl[k] = 0;
      repeat (10) @(negedge clk);
      arst_n = 1'h1;
      for (k = 0; k < 10; k = k + 1) begin
         @(negedge clk);
         en = 1'h0;
         repeat (2) @(negedge clk);
         compare({|cout, oor}, 5'h0);
         cen = (k == 3) ? 4'h7 : 4'hf;
         upd = {4{16'h0001}};
         for (c = 0; c < 4; c = c + 1) begin
            sel[c*6+:6] = (k < 2) ? CORNERS[(k*4+c)*6+:6] : $unsigned($random(seed)) % 42;
            hnd[c*2+:2] = (k < 4) ? k : $random(seed);
            rchk[c] = $random(seed);
            used[c*20+2] = $random(seed);
            a = $random(seed) % 200000;
            px[(c*20)*48+:48] = a;
            px[(c*20+1)*48+:48] = a + 1 + $unsigned($random(seed)) % 300000;
            px[(c*20+2)*48+:48] = pxs(c, 1) + `VAL_ONE;
            for (j = 0; j < 3; j = j + 1) py[(c*20+j)*48+:48] = $random(seed) % 1000000;
            mn[c*48+:48] = $random(seed) % 300000;
            mx[c*48+:48] = mn[c*48+:48] + $unsigned($random(seed)) % 400000;
            v = (k == 2) ? a : $random(seed) % 500000;
            src_lvl[sel[c*6+:6]] = v;
            u_fe.set_level(sel[c*6+:6], v);
         end
         repeat (2) @(negedge clk);
         en = 1'h1;
         wait_all;
      end
      // lost source holds, refresh period follows the update cycle
      @(negedge clk);
      cen = 4'h1;
      upd[15:0] = 16'h0008;
      wait_all;
      @(negedge clk);
      u_fe.drop(sel[5:0]);
      wait_all;
      t1 = tp;
      wait_all;
      compare((tp - t1) / 100, 8 * TICK);
      compare(cin[47:0], src_lvl[sel[5:0]]);
      // averaging: half step with tau equal to the cycle, then settles at dc
      @(negedge clk);
      a = src_lvl[sel[5:0]];
      b = $random(seed) % 900000;
      fen[0] = 1'h1;
      tau[15:0] = 16'h0002;
      upd[15:0] = 16'h0002;
      u_fe.set_level(sel[5:0], b);
      wait_all;
      v = (b - a) / 2;
      v = $signed(cin[47:0]) - a - v;
      compare(v >= -1 && v <= 1, 1'h1);
      repeat (30) wait_all;
      v = $signed(cin[47:0]) - b;
      compare(v >= -1 && v <= 1, 1'h1);
      summarize;
   end
endmodule
